// file: hw/ostc_pkg.sv
/*
 * Shared constants and decode functions for the optical sample timing and
 * configuration block: register addresses, field positions, reset values,
 * timing figures and the sample-rate and burst limit tables.
 * Assumes a 100 MHz core clock and a 32768 Hz or 32000 Hz sampling clock.
 */
package ostc_pkg;

	// Register addresses on the plain register port.
	localparam logic [7:0] ADDR_FE_CFG = 8'h11;
	localparam logic [7:0] ADDR_SR_AVG = 8'h12;
	localparam logic [7:0] ADDR_BURST  = 8'h13;

	// Reset values.
	localparam logic [7:0] RST_FE_CFG = 8'h03;
	localparam logic [7:0] RST_SR_AVG = 8'h88;
	localparam logic [7:0] RST_BURST  = 8'h40;

	// Field positions.
	localparam int FE_AMB_OFF_BIT = 7;
	localparam int FE_OFFSET_BIT  = 6;
	localparam int FE_CH2_LSB     = 4;
	localparam int FE_CH1_LSB     = 2;
	localparam int FE_TINT_LSB    = 0;
	localparam int SR_LSB         = 3;
	localparam int AVG_LSB        = 0;
	localparam int BU_SETTLE_LSB  = 6;
	localparam int BU_RATE_LSB    = 1;
	localparam int BU_EN_BIT      = 0;

	// Dark-current offsets and range base.
	localparam logic [19:0] DARK_OFS_SINGLE = 20'h02000;
	localparam logic [19:0] DARK_OFS_DUAL   = 20'h01000;
	localparam logic [15:0] FS_BASE_NA      = 16'h1000;

	// Sample-rate codes.
	localparam logic [4:0] SR_CODE_MAX = 5'h13;
	localparam logic [4:0] SR_DUAL_LO  = 5'h06;
	localparam logic [4:0] SR_DUAL_HI  = 5'h09;
	localparam logic [3:0] BURST_DIS   = 4'hF;

	// Timing in nanoseconds and the derived 100 MHz cycle counts.
	localparam int CLK_NS     = 10;
	localparam int TINT0_NS   = 14800;
	localparam int TINT1_NS   = 29400;
	localparam int TINT2_NS   = 58700;
	localparam int TINT3_NS   = 117300;
	localparam int SETTLE0_NS = 4000;
	localparam int SETTLE1_NS = 6000;
	localparam int SETTLE2_NS = 8000;
	localparam int SETTLE3_NS = 12000;
	localparam int EXTRA_NS   = 500;
	localparam int TINT0_CYC   = TINT0_NS / CLK_NS;
	localparam int TINT1_CYC   = TINT1_NS / CLK_NS;
	localparam int TINT2_CYC   = TINT2_NS / CLK_NS;
	localparam int TINT3_CYC   = TINT3_NS / CLK_NS;
	localparam int SETTLE0_CYC = SETTLE0_NS / CLK_NS;
	localparam int SETTLE1_CYC = SETTLE1_NS / CLK_NS;
	localparam int SETTLE2_CYC = SETTLE2_NS / CLK_NS;
	localparam int SETTLE3_CYC = SETTLE3_NS / CLK_NS;
	localparam int EXTRA_CYC   = EXTRA_NS / CLK_NS;

	// Sample period per rate code, in sampling-clock ticks.
	localparam logic [12:0] SR_TICKS [0:19] = '{
		13'd1311, 13'd655, 13'd390, 13'd328, 13'd164, 13'd82,
		13'd1311, 13'd655, 13'd390, 13'd328,
		13'd4096, 13'd2048, 13'd1024, 13'd512, 13'd256, 13'd128,
		13'd64, 13'd32, 13'd16, 13'd8};

	// Burst period per burst-rate code, in sampling-clock ticks.
	localparam logic [12:0] BURST_TICKS [0:3] = '{
		13'd4096, 13'd1024, 13'd390, 13'd128};

	function automatic logic sr_is_dual(input logic [4:0] code);
		return (code >= SR_DUAL_LO) && (code <= SR_DUAL_HI);
	endfunction : sr_is_dual

	function automatic logic [12:0] sr_ticks(input logic [4:0] code);
		return SR_TICKS[(code > SR_CODE_MAX) ? SR_CODE_MAX : code];
	endfunction : sr_ticks

	// Fastest rate code allowed for a pulse mode, exposure count and
	// integration time.
	function automatic logic [4:0] sr_max_code(input logic dual,
		input logic [2:0] expo, input logic [1:0] tint);
		logic [4:0] c;
		c = 5'h13;
		if (dual) begin
			case (expo)
				3'h1: c = 5'h09;
				3'h2: c = (tint == 2'h0) ? 5'h09 : 5'h08;
				3'h3: c = 5'h07;
				default: c = 5'h06;
			endcase
		end else begin
			case ({expo, tint})
				5'h04: c = 5'h13;
				5'h05, 5'h06, 5'h08: c = 5'h12;
				5'h07, 5'h09, 5'h0A, 5'h0C, 5'h0D, 5'h10: c = 5'h11;
				5'h13: c = 5'h05;
				5'h1A: c = 5'h05;
				5'h17, 5'h1B: c = 5'h0F;
				5'h1F, 5'h1E: c = (tint == 2'h3) ? 5'h0F : 5'h05;
				default: c = 5'h10;
			endcase
		end
		return c;
	endfunction : sr_max_code

	// Largest averaging code per burst, one nibble per burst rate.
	function automatic logic [3:0] burst_avg_max(input logic [4:0] code,
		input logic [1:0] rate);
		logic [15:0] row;
		case (code)
			5'h00, 5'h06: row = 16'hFFF1;
			5'h01, 5'h07: row = 16'hFF02;
			5'h02, 5'h03, 5'h08, 5'h09: row = 16'hFF13;
			5'h04: row = 16'hF024;
			5'h05: row = 16'hF135;
			5'h0B: row = 16'hFFF0;
			5'h0C: row = 16'hFFF1;
			5'h0D: row = 16'hFF02;
			5'h0E: row = 16'hF013;
			5'h0F: row = 16'hF124;
			5'h10: row = 16'hF235;
			5'h11: row = 16'h0346;
			5'h12: row = 16'h1457;
			5'h13: row = 16'h2567;
			default: row = 16'hFFFF;
		endcase
		return row[rate*4 +: 4];
	endfunction : burst_avg_max

endpackage : ostc_pkg

// file: hw/ostc_avg.sv
/*
 * One channel of the on-chip averager: adds the dark offset to each
 * result, accumulates 2^code results and emits their mean.
 * Assumes in_valid pulses are on the mclk domain and at most one a cycle.
 */
`timescale 1ns/100ps
module ostc_avg #(
	parameter int IW = 19,
	parameter int OW = 20
) (
	input  wire logic          mclk,
	input  wire logic          rstn,
	input  wire logic          clr,
	input  wire logic          in_valid,
	input  wire logic [IW-1:0] in_data,
	input  wire logic [OW-1:0] offset,
	input  wire logic [2:0]    avg_code,
	output logic               out_valid,
	output logic [OW-1:0]      out_data
);
	localparam int AW = OW + 8;

	logic [AW-1:0] acc_r;
	logic [7:0]    cnt_r;
	logic [AW-1:0] sum;
	logic [7:0]    last_cnt;
	logic          done;
	logic [AW-1:0] mean;

	assign sum      = acc_r + AW'(in_data) + AW'(offset);
	assign last_cnt = 8'((9'h001 << avg_code) - 9'h001);
	assign done     = in_valid && (cnt_r == last_cnt);
	assign mean     = sum >> avg_code;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_r     <= '0;
			cnt_r     <= 8'h00;
			out_valid <= 1'b0;
			out_data  <= '0;
		end else begin
			out_valid <= done;
			if (done)
				out_data <= mean[OW-1:0];
			if (clr || done) begin
				acc_r <= '0;
				cnt_r <= 8'h00;
			end else if (in_valid) begin
				acc_r <= sum;
				cnt_r <= cnt_r + 8'h01;
			end
		end
	end
endmodule : ostc_avg

// file: hw/ostc_top.sv
/*
 * Configuration and sample timing of an optical acquisition front end:
 * three configuration registers, rate and averaging limits, sample and
 * burst scheduling, emitter and integration windows, per-channel averaging.
 * Assumes a 100 MHz mclk, a free-running 32768 Hz or 32000 Hz sampling
 * clock on samp_clk_pin and converter results on the mclk domain.
 */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module ostc_top #(
	parameter int TINT2_CYC = ostc_pkg::TINT2_CYC,
	parameter int TINT3_CYC = ostc_pkg::TINT3_CYC
) (
	input  wire logic        mclk,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [7:0]  reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [7:0]  reg_rdata,
	input  wire logic        samp_clk_pin,
	input  wire logic [2:0]  exposure_count,
	input  wire logic        conv_valid,
	input  wire logic [18:0] conv_ch1,
	input  wire logic [18:0] conv_ch2,
	output logic             ambient_cancel_on,
	output logic      [1:0]  ch1_range_sel,
	output logic      [1:0]  ch2_range_sel,
	output logic      [15:0] ch1_full_scale_na,
	output logic      [15:0] ch2_full_scale_na,
	output logic      [4:0]  rate_code_used,
	output logic      [2:0]  avg_code_used,
	output logic             dual_pulse,
	output logic             burst_active,
	output logic             sample_start,
	output logic             emitter_on,
	output logic             integrate_on,
	output logic             result_valid,
	output logic      [19:0] result_ch1,
	output logic      [19:0] result_ch2
);
	typedef enum logic [1:0] {SEQ_IDLE, SEQ_PULSE, SEQ_GAP} ostc_seq_e;

	logic [7:0]  fe_cfg_r;
	logic [7:0]  sr_avg_r;
	logic [7:0]  burst_r;
	logic [7:0]  rdata_nxt;
	logic        wr_fe;
	logic        wr_sr;
	logic        wr_bu;

	// Field views.
	logic [1:0]  tint_sel;
	logic [4:0]  sr_req;
	logic [2:0]  avg_req;
	logic [1:0]  settle_sel;
	logic [1:0]  burst_rate;
	logic        burst_en;

	// Limit evaluation.
	logic [2:0]  expo;
	logic        req_dual;
	logic [4:0]  max_code;
	logic        too_fast;
	logic [4:0]  sr_eff;
	logic [3:0]  bmax;
	logic        burst_dis;
	logic [2:0]  avg_eff;
	logic [19:0] dark_ofs;

	assign wr_fe = reg_wr && (reg_addr == ostc_pkg::ADDR_FE_CFG);
	assign wr_sr = reg_wr && (reg_addr == ostc_pkg::ADDR_SR_AVG);
	assign wr_bu = reg_wr && (reg_addr == ostc_pkg::ADDR_BURST);

	assign tint_sel   = fe_cfg_r[ostc_pkg::FE_TINT_LSB +: 2];
	assign sr_req     = sr_avg_r[ostc_pkg::SR_LSB +: 5];
	assign avg_req    = sr_avg_r[ostc_pkg::AVG_LSB +: 3];
	assign settle_sel = burst_r[ostc_pkg::BU_SETTLE_LSB +: 2];
	assign burst_rate = burst_r[ostc_pkg::BU_RATE_LSB +: 2];
	assign burst_en   = burst_r[ostc_pkg::BU_EN_BIT];

	// Out-of-range exposure counts are treated as the nearest legal count.
	assign expo = (exposure_count == 3'h0) ? 3'h1 :
		(exposure_count > 3'h6) ? 3'h6 : exposure_count;
	// Reserved codes fall through as too fast, so they land on the limit.
	assign req_dual = ostc_pkg::sr_is_dual(sr_req);
	assign max_code = ostc_pkg::sr_max_code(req_dual, expo, tint_sel);
	assign too_fast = (sr_req > ostc_pkg::SR_CODE_MAX) ||
		(ostc_pkg::sr_ticks(sr_req) < ostc_pkg::sr_ticks(max_code));
	assign sr_eff   = too_fast ? max_code : sr_req;
	assign dual_pulse = ostc_pkg::sr_is_dual(sr_eff);

	assign bmax      = ostc_pkg::burst_avg_max(sr_eff, burst_rate);
	assign burst_dis = (bmax == ostc_pkg::BURST_DIS);
	assign avg_eff   = (burst_en && !burst_dis && ({1'b0, avg_req} > bmax)) ?
		bmax[2:0] : avg_req;
	assign dark_ofs  = !fe_cfg_r[ostc_pkg::FE_OFFSET_BIT] ? 20'h00000 :
		dual_pulse ? ostc_pkg::DARK_OFS_DUAL :
		ostc_pkg::DARK_OFS_SINGLE;

	// Register file.  Burst enable is cleared by hardware one cycle after
	// software sets it into a configuration that no burst length fits.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			fe_cfg_r <= ostc_pkg::RST_FE_CFG;
			sr_avg_r <= ostc_pkg::RST_SR_AVG;
			burst_r  <= ostc_pkg::RST_BURST;
		end else begin
			if (wr_fe)
				fe_cfg_r <= reg_wdata;
			if (wr_sr)
				sr_avg_r <= reg_wdata;
			if (wr_bu)
				burst_r <= reg_wdata & 8'hC7;
			else if (burst_en && burst_dis)
				burst_r[ostc_pkg::BU_EN_BIT] <= 1'b0;
		end
	end

	always_comb begin
		rdata_nxt = 8'h00;
		if (reg_rd) begin
			case (reg_addr)
				ostc_pkg::ADDR_FE_CFG: rdata_nxt = fe_cfg_r;
				ostc_pkg::ADDR_SR_AVG: rdata_nxt = {sr_eff, avg_req};
				ostc_pkg::ADDR_BURST:  rdata_nxt = burst_r;
				default:               rdata_nxt = 8'h00;
			endcase
		end
	end

	// Decoded configuration outputs.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			reg_rdata         <= 8'h00;
			ambient_cancel_on <= 1'b1;
			ch1_range_sel     <= 2'h0;
			ch2_range_sel     <= 2'h0;
			ch1_full_scale_na <= ostc_pkg::FS_BASE_NA;
			ch2_full_scale_na <= ostc_pkg::FS_BASE_NA;
			rate_code_used    <= 5'h11;
			avg_code_used     <= 3'h0;
			burst_active      <= 1'b0;
		end else begin
			reg_rdata         <= rdata_nxt;
			ambient_cancel_on <= !fe_cfg_r[ostc_pkg::FE_AMB_OFF_BIT];
			ch1_range_sel     <= fe_cfg_r[ostc_pkg::FE_CH1_LSB +: 2];
			ch2_range_sel     <= fe_cfg_r[ostc_pkg::FE_CH2_LSB +: 2];
			ch1_full_scale_na <= ostc_pkg::FS_BASE_NA <<
				fe_cfg_r[ostc_pkg::FE_CH1_LSB +: 2];
			ch2_full_scale_na <= ostc_pkg::FS_BASE_NA <<
				fe_cfg_r[ostc_pkg::FE_CH2_LSB +: 2];
			rate_code_used    <= sr_eff;
			avg_code_used     <= avg_eff;
			burst_active      <= burst_en && !burst_dis;
		end
	end

	// Sampling clock crossing; the second and third stages feed the edge detector.
	logic sclk_s1_r;
	logic sclk_s2_r;
	logic sclk_s3_r;
	logic tick;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sclk_s1_r <= 1'b0;
			sclk_s2_r <= 1'b0;
			sclk_s3_r <= 1'b0;
		end else begin
			sclk_s1_r <= samp_clk_pin;
			sclk_s2_r <= sclk_s1_r;
			sclk_s3_r <= sclk_s2_r;
		end
	end
	assign tick = sclk_s2_r && !sclk_s3_r;

	// Sample and burst scheduling in sampling-clock ticks, so a 32000 Hz
	// clock scales every rate by the same factor.
	logic [12:0] samp_cnt_r;
	logic [12:0] burst_cnt_r;
	logic [7:0]  burst_left_r;
	logic        bursting;
	logic        samp_due;
	logic        burst_wrap;
	logic        fire;
	logic [12:0] period;
	logic [12:0] bperiod;

	assign bursting   = burst_en && !burst_dis;
	assign period     = ostc_pkg::sr_ticks(sr_eff);
	assign bperiod    = ostc_pkg::BURST_TICKS[burst_rate];
	assign burst_wrap = tick && bursting && (burst_cnt_r >= bperiod - 13'd1);
	assign samp_due   = tick && (samp_cnt_r >= period - 13'd1);
	assign fire = bursting ? (burst_wrap || (samp_due && burst_left_r != 8'h00))
		: samp_due;

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			samp_cnt_r   <= 13'h0000;
			burst_cnt_r  <= 13'h0000;
			burst_left_r <= 8'h00;
		end else begin
			if (fire || burst_wrap)
				samp_cnt_r <= 13'h0000;
			else if (tick)
				samp_cnt_r <= samp_cnt_r + 13'd1;
			if (!bursting || burst_wrap)
				burst_cnt_r <= 13'h0000;
			else if (tick)
				burst_cnt_r <= burst_cnt_r + 13'd1;
			if (!bursting)
				burst_left_r <= 8'h00;
			else if (burst_wrap)
				burst_left_r <= 8'((9'h001 << avg_eff) - 9'h001);
			else if (fire)
				burst_left_r <= burst_left_r - 8'h01;
		end
	end

	// Exposure sequencer: one emitter pulse per exposure and per pulse.
	logic [13:0] tint_cyc;
	logic [13:0] settle_cyc;
	logic [13:0] pw_cyc;
	logic [13:0] cyc_r;
	logic [3:0]  pulses_left_r;
	logic [3:0]  pulses_total;
	ostc_seq_e   seq_r;
	ostc_seq_e   seq_nxt;
	logic        pulse_end;

	assign tint_cyc = (tint_sel == 2'h0) ? 14'(ostc_pkg::TINT0_CYC) :
		(tint_sel == 2'h1) ? 14'(ostc_pkg::TINT1_CYC) :
		(tint_sel == 2'h2) ? 14'(TINT2_CYC) : 14'(TINT3_CYC);
	assign settle_cyc = (settle_sel == 2'h0) ? 14'(ostc_pkg::SETTLE0_CYC) :
		(settle_sel == 2'h1) ? 14'(ostc_pkg::SETTLE1_CYC) :
		(settle_sel == 2'h2) ? 14'(ostc_pkg::SETTLE2_CYC) :
		14'(ostc_pkg::SETTLE3_CYC);
	assign pw_cyc = tint_cyc + settle_cyc + 14'(ostc_pkg::EXTRA_CYC);
	assign pulses_total = dual_pulse ? {expo, 1'b0} : {1'b0, expo};
	assign pulse_end = (seq_r == SEQ_PULSE) && (cyc_r == pw_cyc - 14'd1);

	always_comb begin
		seq_nxt = seq_r;
		case (seq_r)
			SEQ_IDLE:  if (fire) seq_nxt = SEQ_PULSE;
			SEQ_PULSE: if (pulse_end)
				seq_nxt = (pulses_left_r == 4'h1) ? SEQ_IDLE : SEQ_GAP;
			SEQ_GAP:   seq_nxt = SEQ_PULSE;
			default:   seq_nxt = SEQ_IDLE;
		endcase
	end

	// A sample request that lands while a sequence runs is dropped; the
	// rate limits keep this from happening in legal configurations.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			seq_r         <= SEQ_IDLE;
			cyc_r         <= 14'h0000;
			pulses_left_r <= 4'h0;
			sample_start  <= 1'b0;
			emitter_on    <= 1'b0;
			integrate_on  <= 1'b0;
		end else begin
			seq_r        <= seq_nxt;
			sample_start <= (seq_r == SEQ_IDLE) && fire;
			if (seq_r == SEQ_IDLE)
				pulses_left_r <= pulses_total;
			else if (pulse_end)
				pulses_left_r <= pulses_left_r - 4'h1;
			cyc_r <= (seq_r == SEQ_PULSE && !pulse_end) ?
				cyc_r + 14'd1 : 14'h0000;
			emitter_on <= (seq_nxt == SEQ_PULSE);
			integrate_on <= (seq_r == SEQ_PULSE) && !pulse_end &&
				(cyc_r + 14'd1 >= settle_cyc) &&
				(cyc_r + 14'd1 < settle_cyc + tint_cyc);
		end
	end

	// Averaging restarts on a write to any of the three configuration registers and at each burst start, not on an exposure_count change.
	logic avg_clr;
	logic [1:0] ch_valid;

	assign avg_clr = wr_sr || wr_fe || wr_bu || burst_wrap;

	ostc_avg #(
		.IW (19),
		.OW (20)
	) u_avg_ch1 (
		.mclk      (mclk),
		.rstn      (rstn),
		.clr       (avg_clr),
		.in_valid  (conv_valid),
		.in_data   (conv_ch1),
		.offset    (dark_ofs),
		.avg_code  (avg_eff),
		.out_valid (ch_valid[0]),
		.out_data  (result_ch1)
	);

	ostc_avg #(
		.IW (19),
		.OW (20)
	) u_avg_ch2 (
		.mclk      (mclk),
		.rstn      (rstn),
		.clr       (avg_clr),
		.in_valid  (conv_valid),
		.in_data   (conv_ch2),
		.offset    (dark_ofs),
		.avg_code  (avg_eff),
		.out_valid (ch_valid[1]),
		.out_data  (result_ch2)
	);

	assign result_valid = ch_valid[0] && ch_valid[1];
endmodule : ostc_top

// file: tb/ostc_top_properties.sv
/*
 * Concurrent checks on the ports of ostc_top: decode, rate limits, pulses.
 * Assumes a single mclk domain; bound to every ostc_top instance.
 */
`timescale 1ns/100ps
module ostc_chk (
	input wire logic        mclk,
	input wire logic        rstn,
	input wire logic [7:0]  reg_addr,
	input wire logic [7:0]  reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_rdata,
	input wire logic        conv_valid,
	input wire logic [18:0] conv_ch1,
	input wire logic        ambient_cancel_on,
	input wire logic [1:0]  ch1_range_sel,
	input wire logic [15:0] ch1_full_scale_na,
	input wire logic [4:0]  rate_code_used,
	input wire logic [2:0]  avg_code_used,
	input wire logic        dual_pulse,
	input wire logic        burst_active,
	input wire logic        sample_start,
	input wire logic        emitter_on,
	input wire logic        integrate_on,
	input wire logic        result_valid,
	input wire logic [19:0] result_ch1
);
	logic       ofs_r;
	wire  logic wr_fe = reg_wr && reg_addr == 8'h11;
	// Shadow of the dark-offset bit, so the offset sum can be predicted.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn)
			ofs_r <= 1'b0;
		else if (wr_fe)
			ofs_r <= reg_wdata[6];
	end
	default clocking dc @(posedge mclk); endclocking
	default disable iff (!rstn);
	chk_fe_decode:
	assert property (wr_fe |-> ##2 ambient_cancel_on == !$past(reg_wdata[7], 2)
		&& ch1_range_sel == $past(reg_wdata[3:2], 2))
		else $error("front end fields not applied");
	chk_full_scale:
	assert property (ch1_full_scale_na == (16'h1000 << ch1_range_sel))
		else $error("full scale does not follow range");
	// The pulse mode output is decoded without a register, so it leads the
	// registered rate code by one cycle.
	chk_dual_code:
	assert property ($past(dual_pulse) == (rate_code_used >= 5'h06
		&& rate_code_used <= 5'h09)) else $error("pulse mode decode wrong");
	chk_rate_legal:
	assert property (rate_code_used <= 5'h13) else $error("rate code reserved");
	chk_rate_read:
	assert property (reg_rd && reg_addr == 8'h12 |=>
		reg_rdata[7:3] == rate_code_used) else $error("rate readback");
	chk_integ_window:
	assert property (integrate_on |-> emitter_on)
		else $error("integration outside emitter pulse");
	chk_start_pulse:
	assert property (sample_start |=> !sample_start && emitter_on)
		else $error("sample start malformed");
	chk_result_cause:
	assert property (result_valid |-> $past(conv_valid))
		else $error("result without conversion");
	chk_dark_offset:
	assert property (conv_valid && !reg_wr && !$past(reg_wr)
		&& avg_code_used == 3'h0 && !burst_active |=> result_valid
		&& result_ch1 == {1'b0, $past(conv_ch1)} + ($past(ofs_r)
		? ($past(dual_pulse) ? 20'h01000 : 20'h02000) : 20'h00000))
		else $error("dark offset sum wrong");
endmodule : ostc_chk

bind ostc_top ostc_chk u_chk (
	.mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
	.conv_valid(conv_valid), .conv_ch1(conv_ch1),
	.ambient_cancel_on(ambient_cancel_on), .ch1_range_sel(ch1_range_sel),
	.ch1_full_scale_na(ch1_full_scale_na), .rate_code_used(rate_code_used),
	.avg_code_used(avg_code_used), .dual_pulse(dual_pulse),
	.burst_active(burst_active), .sample_start(sample_start),
	.emitter_on(emitter_on), .integrate_on(integrate_on),
	.result_valid(result_valid), .result_ch1(result_ch1)
);

// file: tb/ostc_top_bench.sv
/*
 * Self-checking bench for ostc_top with an integer model of its rules.
 * Assumes short integration parameters and a scaled sampling clock.
 */
`timescale 1ns/100ps
module ostc_top_bench;
	logic        mclk = 1'b0, rstn = 1'b0, wr = 1'b0, rd = 1'b0, cv = 1'b0;
	logic        scl = 1'b0;
	logic [7:0]  ad = 8'h00, wd = 8'h00, rdv, rdata, d11, d12, d13;
	logic [2:0]  expo = 3'h1, avgu;
	logic [18:0] c1 = 19'h00000, c2 = 19'h00000;
	logic        amb, dual, burst, sst, emit, integ, rv;
	logic [1:0]  r1, r2;
	logic [15:0] fs1, fs2;
	logic [4:0]  rate;
	logic [19:0] res1, res2;
	int          err_total = 0, comparisons = 0, eff, bm, bon, s1, s2, v;
	real         samp_half = 320.0;
	localparam int SPS [20] = '{25, 50, 84, 100, 200, 400, 25, 50, 84, 100,
		8, 16, 32, 64, 128, 256, 512, 1024, 2048, 4096};
	localparam int MX1 [24] = '{4096, 2048, 2048, 1024, 2048, 1024, 1024,
		512, 1024, 1024, 512, 512, 1024, 512, 512, 400, 512, 512, 512, 256,
		512, 512, 400, 256};
	// Nibbles give the largest averaging code for burst rates 0 to 3; F is off.
	localparam int BT [20] = '{16'h1FFF, 16'h20FF, 16'h31FF, 16'h31FF,
		16'h420F, 16'h531F, 16'h1FFF, 16'h20FF, 16'h31FF, 16'h31FF, 16'hFFFF,
		16'h0FFF, 16'h1FFF, 16'h20FF, 16'h310F, 16'h421F, 16'h532F, 16'h6430,
		16'h7541, 16'h7652};

	always #5 mclk = ~mclk;
	always #(samp_half) scl = ~scl;

	ostc_top #(.TINT2_CYC(100), .TINT3_CYC(200)) dut (
		.mclk(mclk), .rstn(rstn), .reg_addr(ad), .reg_wdata(wd),
		.reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .samp_clk_pin(scl),
		.exposure_count(expo), .conv_valid(cv), .conv_ch1(c1),
		.conv_ch2(c2), .ambient_cancel_on(amb), .ch1_range_sel(r1),
		.ch2_range_sel(r2), .ch1_full_scale_na(fs1),
		.ch2_full_scale_na(fs2), .rate_code_used(rate),
		.avg_code_used(avgu), .dual_pulse(dual), .burst_active(burst),
		.sample_start(sst), .emitter_on(emit), .integrate_on(integ),
		.result_valid(rv), .result_ch1(res1), .result_ch2(res2)
	);

	task automatic end_of_test;
		if (err_total == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_of_test

	task automatic fail(input string m);
		err_total++;
		$display("CHECK FAILED %0t %s", $time, m);
	endtask : fail

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp)
			fail($sformatf("got %0h expected %0h", got, exp));
	endtask : cmp

	task automatic cmp_near(input int got, input int exp);
		comparisons++;
		if (got > exp + 1 || got < exp - 1)
			fail($sformatf("period %0d expected %0d", got, exp));
	endtask : cmp_near

	task automatic step;
		@(posedge mclk) #1;
	endtask : step

	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		ad <= a;
		wd <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask : wreg

	task automatic rreg(input logic [7:0] a);
		@(posedge mclk);
		rd <= 1'b1;
		ad <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 rdv = rdata;
	endtask : rreg

	// Bounded wait for a fresh rising level on sample_start or emitter_on.
	task automatic wait_rise(input bit on_start);
		int n;
		n = 0;
		while ((on_start ? sst : emit) !== 1'b0 && n < 6000) begin
			step();
			n++;
		end
		while ((on_start ? sst : emit) !== 1'b1 && n < 6000) begin
			step();
			n++;
		end
		if (n >= 6000) begin
			fail("wait timed out");
			end_of_test();
		end
	endtask : wait_rise

	function automatic int eff_rate(input int req, input int x, input int t);
		int e, dl, mx;
		e = (x == 0) ? 1 : (x == 7) ? 6 : x;
		dl = (req >= 6 && req <= 9);
		if (dl)
			mx = (e == 1) ? 100 : (e == 2) ? (t == 0 ? 100 : 84) : (e == 3) ? 50 : 25;
		else
			mx = MX1[(e - 1) * 4 + t];
		if (req <= 19 && SPS[req] <= mx)
			return req;
		for (int c = 19; c >= 0; c--)
			if ((c >= 6 && c <= 9) == dl && SPS[c] == mx)
				return c;
		return 0;
	endfunction : eff_rate

	task automatic pulse_case(input int t, input int s);
		int cnt, di, ni, st, ti;
		st = (s == 3) ? 1200 : 400 + 200 * s;
		ti = (t == 2) ? 100 : 200;
		wreg(8'h11, t[7:0]);
		wreg(8'h12, 8'h90);
		wreg(8'h13, {s[1:0], 6'h00});
		wait_rise(1'b0);
		cnt = 0;
		di = -1;
		ni = 0;
		while (emit === 1'b1 && cnt < 5000) begin
			if (integ === 1'b1 && di < 0)
				di = cnt;
			ni += (integ === 1'b1);
			cnt++;
			step();
		end
		cmp(cnt, ti + st + 50);
		cmp(di, st);
		cmp(ni, ti);
	endtask : pulse_case

	task automatic period_case(input real half, input int exp);
		int n;
		samp_half = half;
		wait_rise(1'b1);
		wait_rise(1'b1);
		n = 0;
		do begin
			step();
			n++;
		end while (sst !== 1'b1 && n < 3000);
		cmp_near(n, exp);
	endtask : period_case

	initial begin
		void'($urandom(23726));
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		cmp({amb, rate, avgu, fs1}, {1'b1, 5'h11, 3'h0, 16'h1000});
		wreg(8'h20, 8'hFF);
		rreg(8'h11);
		cmp(rdv, 8'h03);
		rreg(8'h12);
		cmp(rdv, 8'h88);
		rreg(8'h20);
		cmp(rdv, 8'h00);
		for (int i = 0; i < 40; i++) begin
			@(posedge mclk) expo <= 3'($urandom);
			d11 = 8'($urandom);
			d12 = 8'($urandom);
			d13 = 8'($urandom);
			wreg(8'h11, d11);
			wreg(8'h12, d12);
			wreg(8'h13, d13);
			repeat (4) step();
			eff = eff_rate(d12[7:3], expo, d11[1:0]);
			bm = (BT[eff] >> (12 - 4 * d13[2:1])) & 15;
			bon = d13[0] && bm != 15;
			cmp({amb, r1, r2, fs2}, {~d11[7], d11[3:2], d11[5:4],
				16'h1000 << d11[5:4]});
			cmp(dual, eff >= 6 && eff <= 9);
			cmp(rate, eff);
			cmp(burst, bon);
			cmp(avgu, (bon && bm < d12[2:0]) ? bm : d12[2:0]);
			rreg(8'h12);
			cmp(rdv, {eff[4:0], d12[2:0]});
			rreg(8'h13);
			cmp(rdv, {d13[7:6], 3'h0, d13[2:1], bon[0]});
		end
		wreg(8'h13, 8'h40);
		expo <= 3'h1;
		for (int k = 0; k < 4; k++) begin
			wreg(8'h11, {1'b0, k[0], 6'h03});
			wreg(8'h12, {k[1] ? 5'h06 : 5'h11, k[2:0]});
			repeat (3) @(posedge mclk);
			s1 = 0;
			s2 = 0;
			for (int j = 0; j < (1 << k); j++) begin
				v = k[0] ? (k[1] ? 4096 : 8192) : 0;
				@(posedge mclk);
				cv <= 1'b1;
				c1 <= 19'($urandom);
				c2 <= 19'($urandom);
				#1 s1 += c1 + v;
				s2 += c2 + v;
			end
			@(posedge mclk);
			cv <= 1'b0;
			#1 cmp(rv, 1'b1);
			cmp({res1, res2}, {20'(s1 >> k), 20'(s2 >> k)});
		end
		pulse_case(2, 0);
		pulse_case(3, 3);
		wreg(8'h13, 8'h00);
		wreg(8'h11, 8'h02);
		period_case(320.0, 1024);
		period_case(327.5, 1048);
		// Burst of two conversions at the fastest burst rate: the window
		// covers two burst starts and stops well before the third.
		wreg(8'h12, 8'h91);
		wreg(8'h13, 8'h07);
		v = 0;
		for (int i = 0; i < 20480; i++) begin
			step();
			v += (sst === 1'b1);
		end
		cmp(v, 4);
		end_of_test();
	end
endmodule : ostc_top_bench
